//--- blams_pkg.sv
// package: byte-lane and address-modifier constants and types
`default_nettype none
package blams_pkg;
	// ==========================================================
	// byte selection
	localparam logic [1:0] BYTE_0 = 2'h0;
	localparam logic [1:0] BYTE_1 = 2'h1;
	localparam logic [1:0] BYTE_2 = 2'h2;
	localparam logic [1:0] BYTE_3 = 2'h3;
	localparam int GROUP_LSB = 2;
	localparam int SHORT_MSB = 15;
	localparam int STD_MSB = 23;
	localparam int EXT_MSB = 31;
	localparam logic [3:0] LANES_NONE = 4'h0;
	// ==========================================================
	// address modifier codes
	localparam logic [5:0] AM_STD_SUP_BLK = 6'h3F;
	localparam logic [5:0] AM_STD_SUP_PGM = 6'h3E;
	localparam logic [5:0] AM_STD_SUP_DAT = 6'h3D;
	localparam logic [5:0] AM_STD_USR_BLK = 6'h3B;
	localparam logic [5:0] AM_STD_USR_PGM = 6'h3A;
	localparam logic [5:0] AM_STD_USR_DAT = 6'h39;
	localparam logic [5:0] AM_SHORT_SUP = 6'h2D;
	localparam logic [5:0] AM_SHORT_USR = 6'h29;
	localparam logic [5:0] AM_EXT_SUP_BLK = 6'h0F;
	localparam logic [5:0] AM_EXT_SUP_PGM = 6'h0E;
	localparam logic [5:0] AM_EXT_SUP_DAT = 6'h0D;
	localparam logic [5:0] AM_EXT_USR_BLK = 6'h0B;
	localparam logic [5:0] AM_EXT_USR_PGM = 6'h0A;
	localparam logic [5:0] AM_EXT_USR_DAT = 6'h09;
	localparam logic [1:0] AM_USER_TOP = 2'h1;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		BLAMS_W_NONE = 2'h0,
		BLAMS_W_SHORT = 2'h1,
		BLAMS_W_STD = 2'h2,
		BLAMS_W_EXT = 2'h3
	} blams_width_t;
	typedef enum logic [2:0] {
		BLAMS_K_SINGLE = 3'h0,
		BLAMS_K_DOUBLE = 3'h1,
		BLAMS_K_QUAD = 3'h2,
		BLAMS_K_UNALIGN = 3'h3,
		BLAMS_K_BLK1 = 3'h4,
		BLAMS_K_BLK2 = 3'h5,
		BLAMS_K_BLK4 = 3'h6,
		BLAMS_K_ADDR = 3'h7
	} blams_kind_t;
	typedef enum logic [1:0] {
		BLAMS_M_IDLE = 2'h0,
		BLAMS_M_ADDR = 2'h1,
		BLAMS_M_DATA = 2'h2,
		BLAMS_M_GAP = 2'h3
	} blams_mstate_t;
endpackage
`default_nettype wire

//--- blams_if.sv
// interface: backplane selection lines between master and slave ends
`default_nettype none
interface blams_if;
	logic [31:1] addr;
	logic [5:0] am;
	logic as_n;
	logic ds1_n;
	logic ds0_n;
	logic lword_n;
	logic dtack_n;
	logic berr_n;
	modport master (output addr, am, as_n, ds1_n, ds0_n, lword_n, input dtack_n, berr_n);
	modport slave (input addr, am, as_n, ds1_n, ds0_n, lword_n, output dtack_n, berr_n);
endinterface
`default_nettype wire

//--- blams_sync.sv
// two-flop synchroniser for a bus of asynchronous lines
`default_nettype none
module blams_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// lines
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// first stage read only by second stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- blams_slave.sv
// slave end: decodes byte lanes and address width from the selection lines
// How it works
// RULE_01: byte category is low two address bits
// RULE_02: master puts group index on A02-A31
// RULE_03: strobes, A01, LWORD pick the bytes
// RULE_04: master never settles on two illegal patterns
// RULE_05: BYTE(1-2) may pass illegal patterns briefly
// RULE_06: slave decodes settled levels, not first strobe
// RULE_07: LWORD low with A01 high means both
// RULE_08: LWORD low A01 high needs both strobes
// RULE_09: address-only cycle moves no data
// RULE_10: single byte codes use LWORD high
// RULE_11: double byte codes, both strobes, LWORD high
// RULE_12: quad byte is all four lines low
// RULE_13: unaligned codes use LWORD low
// RULE_14: RMW uses plain cycle selection codes
// RULE_15: single-byte block alternates strobes, wraps 3-0
// RULE_16: A01 valid only until first acknowledge
// RULE_17: double-byte block alternates pairs each transfer
// RULE_18: quad block holds all four lines low
// RULE_19: six-bit modifier drives with each transfer
// RULE_20: compare address bits the modifier class implies
// RULE_21: defined codes keep their assigned meanings
// RULE_22: reserved modifier gets no acknowledge
// RULE_23: standard and short code values fixed
// RULE_24: present four lane enables and width
`default_nettype none
module blams_slave (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus side
	blams_if.slave bus,
	// window configuration
	input wire logic [31:2] base_addr,
	input wire logic user_am_en,
	// local storage side
	output logic sel_valid,
	output logic [3:0] lane_en,
	output logic [31:2] group_addr,
	output blams_pkg::blams_width_t addr_width,
	output logic [5:0] am_code,
	output logic block_xfer,
	output logic addr_only,
	input wire logic local_done,
	input wire logic local_err
);
	// ==========================================================
	// synchronised bus inputs
	logic [31:1] addr_s;
	logic [5:0] am_s;
	logic as_s, ds1_s, ds0_s, lw_s;
	logic [31:1] addr_p;
	logic [5:0] am_p;
	logic [3:0] ctl_p;
	logic [3:0] ctl_s;
	blams_sync #(.W(31), .INIT('0)) u_sa (.clk_sys(clk_sys), .rst(rst), .d(bus.addr), .q(addr_p));
	blams_sync #(.W(6), .INIT('0)) u_sm (.clk_sys(clk_sys), .rst(rst), .d(bus.am), .q(am_p));
	blams_sync #(.W(4), .INIT('1)) u_sc (.clk_sys(clk_sys), .rst(rst),
		.d({bus.as_n, bus.ds1_n, bus.ds0_n, bus.lword_n}), .q(ctl_p));
	assign addr_s = addr_p;
	assign am_s = am_p;
	assign ctl_s = ctl_p;
	assign as_s = ctl_s[3];
	assign ds1_s = ctl_s[2];
	assign ds0_s = ctl_s[1];
	assign lw_s = ctl_s[0];

	// ==========================================================
	// modifier decode
	function automatic blams_pkg::blams_width_t am_width(input logic [5:0] am, input logic usr);
		case (am)
			blams_pkg::AM_SHORT_SUP, blams_pkg::AM_SHORT_USR: am_width = blams_pkg::BLAMS_W_SHORT; // [RULE_23]
			blams_pkg::AM_STD_SUP_BLK, blams_pkg::AM_STD_SUP_PGM, blams_pkg::AM_STD_SUP_DAT,
			blams_pkg::AM_STD_USR_BLK, blams_pkg::AM_STD_USR_PGM,
			blams_pkg::AM_STD_USR_DAT: am_width = blams_pkg::BLAMS_W_STD; // [RULE_23]
			blams_pkg::AM_EXT_SUP_BLK, blams_pkg::AM_EXT_SUP_PGM, blams_pkg::AM_EXT_SUP_DAT,
			blams_pkg::AM_EXT_USR_BLK, blams_pkg::AM_EXT_USR_PGM,
			blams_pkg::AM_EXT_USR_DAT: am_width = blams_pkg::BLAMS_W_EXT;
			default: begin
				// user codes decoded as extended only when enabled; reserved stay none
				if (am[5:4] == blams_pkg::AM_USER_TOP && usr) begin
					am_width = blams_pkg::BLAMS_W_EXT; // [RULE_21]
				end else begin
					am_width = blams_pkg::BLAMS_W_NONE; // [RULE_22]
				end
			end
		endcase
	endfunction

	function automatic logic am_is_block(input logic [5:0] am);
		am_is_block = (am == blams_pkg::AM_STD_SUP_BLK) || (am == blams_pkg::AM_STD_USR_BLK) ||
			(am == blams_pkg::AM_EXT_SUP_BLK) || (am == blams_pkg::AM_EXT_USR_BLK);
	endfunction

	// index of the lowest enabled lane; odd block starts are only known from the strobes
	function automatic logic [1:0] low_lane(input logic [3:0] l);
		if (l[0]) begin
			low_lane = 2'h0;
		end else if (l[1]) begin
			low_lane = 2'h1;
		end else if (l[2]) begin
			low_lane = 2'h2;
		end else begin
			low_lane = 2'h3;
		end
	endfunction

	// lane decode from settled levels; bit n = BYTE(n)
	function automatic logic [3:0] lanes(input logic d1, input logic d0, input logic a1,
			input logic lw);
		logic [3:0] l;
		l = blams_pkg::LANES_NONE;
		if (!lw && a1) begin
			l = 4'h6; // [RULE_07] BYTE(1-2), strobes implied
		end else if (!(d1 && d0)) begin
			case ({lw, a1})
				// quad, BYTE(0-2) or BYTE(1-3): middle lanes always, ends by strobe
				2'h0: l = {~d0, 2'h3, ~d1}; // [RULE_12] [RULE_13] [RULE_14]
				2'h2: l = {2'h0, ~d0, ~d1}; // [RULE_10] [RULE_11]
				2'h3: l = {~d0, ~d1, 2'h0};
				default: l = blams_pkg::LANES_NONE;
			endcase
		end
		lanes = l; // [RULE_03]
	endfunction

	function automatic logic addr_hit(input logic [31:2] a, input logic [31:2] b,
			input blams_pkg::blams_width_t w);
		case (w)
			blams_pkg::BLAMS_W_SHORT: addr_hit = a[blams_pkg::SHORT_MSB:2] == b[blams_pkg::SHORT_MSB:2];
			blams_pkg::BLAMS_W_STD: addr_hit = a[blams_pkg::STD_MSB:2] == b[blams_pkg::STD_MSB:2];
			blams_pkg::BLAMS_W_EXT: addr_hit = a == b; // [RULE_20]
			default: addr_hit = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// settle detection: strobe pattern must hold two samples
	logic [1:0] ds_prev_q;
	logic settled;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ds_prev_q <= 2'h3;
		end else begin
			ds_prev_q <= {ds1_s, ds0_s};
		end
	end
	assign settled = (ds_prev_q == {ds1_s, ds0_s}); // [RULE_06]

	// ==========================================================
	// cycle tracking
	logic active_q, first_q, acked_q, sel_q;
	logic [1:0] byte_q;
	blams_pkg::blams_width_t w_now;
	logic hit_now, strobe_low, blk_now;
	assign w_now = am_width(am_s, user_am_en);
	assign hit_now = addr_hit(addr_s[31:2], base_addr, w_now);
	assign strobe_low = !ds1_s || !ds0_s;
	assign blk_now = am_is_block(am_s);

	// address phase latch, first-transfer tracking
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			active_q <= 1'b0;
			first_q <= 1'b1;
			byte_q <= blams_pkg::BYTE_0;
			group_addr <= '0;
			addr_width <= blams_pkg::BLAMS_W_NONE;
			am_code <= '0;
			block_xfer <= 1'b0;
		end else if (as_s) begin
			active_q <= 1'b0;
			first_q <= 1'b1;
		end else if (!active_q) begin
			active_q <= hit_now; // [RULE_22]
			group_addr <= addr_s[31:2]; // [RULE_02]
			addr_width <= w_now;
			am_code <= am_s; // [RULE_19]
			block_xfer <= blk_now;
			byte_q <= {addr_s[1], 1'b0}; // [RULE_01]
		end else if (sel_q && acked_q && !strobe_low) begin
			// advance the block pointer once per transfer, wrapping
			first_q <= 1'b0; // [RULE_16]
			if (block_xfer) begin
				// next start is the lowest lane just used plus one byte or one pair
				byte_q <= low_lane(lane_en) + (((lane_en[0] && lane_en[1]) ||
					(lane_en[2] && lane_en[3])) ? 2'h2 : 2'h1); // [RULE_15] [RULE_17]
			end
		end
	end

	// lane select for this transfer
	logic [3:0] ln_d;
	always_comb begin
		ln_d = lanes(ds1_s, ds0_s, addr_s[1], lw_s);
		if (block_xfer && !first_q) begin
			// later block transfers ignore A01 and LWORD
			if (!ds1_s && !ds0_s) begin
				ln_d = byte_q[1] ? 4'hC : 4'h3; // [RULE_17]
				if (lane_en == 4'hF) begin
					ln_d = 4'hF; // [RULE_18]
				end
			end else begin
				ln_d = 4'h1 << byte_q; // [RULE_15]
			end
		end
	end

	// selection valid while strobe settled and acknowledge pending
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sel_q <= 1'b0;
			acked_q <= 1'b0;
			lane_en <= blams_pkg::LANES_NONE;
		end else if (!active_q || !strobe_low) begin
			sel_q <= 1'b0; // [RULE_09]
			acked_q <= 1'b0;
		end else if (!sel_q && settled) begin
			sel_q <= 1'b1;
			lane_en <= ln_d; // [RULE_24]
		end else if (sel_q && (local_done || local_err)) begin
			acked_q <= 1'b1;
		end
	end
	assign sel_valid = sel_q && !acked_q;
	assign addr_only = active_q && !strobe_low;

	// acknowledge outputs
	logic dtack_q, berr_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dtack_q <= 1'b1;
			berr_q <= 1'b1;
		end else begin
			dtack_q <= !(acked_q && !local_err && strobe_low) && !(sel_q && local_done && !local_err);
			berr_q <= !(sel_q && local_err && strobe_low) && !(acked_q && !dtack_q ? 1'b0 : berr_q == 1'b0 && strobe_low);
		end
	end
	assign bus.dtack_n = dtack_q;
	assign bus.berr_n = berr_q;
endmodule
`default_nettype wire

//--- blams_master.sv
// master end: encodes byte selection and modifier onto the bus lines
`default_nettype none
module blams_master (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus side
	blams_if.master bus,
	// user request
	input wire logic req_valid,
	output logic req_ready,
	input wire blams_pkg::blams_kind_t req_kind,
	input wire logic [31:0] req_addr,
	input wire logic [1:0] req_len,
	input wire logic [5:0] req_am,
	input wire logic [7:0] req_beats,
	// completion
	output logic beat_done,
	output logic beat_err,
	output logic busy
);
	// ==========================================================
	// acknowledge synchroniser
	logic [1:0] ack_s;
	logic dtack_s, berr_s;
	blams_sync #(.W(2), .INIT('1)) u_ack (.clk_sys(clk_sys), .rst(rst),
		.d({bus.dtack_n, bus.berr_n}), .q(ack_s));
	assign dtack_s = ack_s[1];
	assign berr_s = ack_s[0];

	// strobe/A01/LWORD for first transfer; bit order {ds1,ds0,a01,lw}
	function automatic logic [3:0] enc(input blams_pkg::blams_kind_t k, input logic [1:0] b,
			input logic [1:0] len);
		case (k)
			// read-modify-write cycles reuse these same codes [RULE_14]
			blams_pkg::BLAMS_K_SINGLE, blams_pkg::BLAMS_K_BLK1: enc = {b[0], ~b[0], b[1], 1'b1}; // [RULE_10]
			blams_pkg::BLAMS_K_DOUBLE, blams_pkg::BLAMS_K_BLK2: enc = {2'h0, b[1], 1'b1}; // [RULE_11]
			blams_pkg::BLAMS_K_QUAD, blams_pkg::BLAMS_K_BLK4: enc = 4'h0; // [RULE_12] [RULE_18]
			blams_pkg::BLAMS_K_UNALIGN: begin
				// any len but 1 = three bytes from b, len 1 = BYTE(1-2)
				if (len == 2'h1) begin
					enc = 4'h2; // [RULE_13] [RULE_08]
				end else begin
					enc = {b[0], ~b[0], 2'h0}; // [RULE_13] [RULE_04]
				end
			end
			default: enc = {2'h3, b[1], 1'b1}; // [RULE_09]
		endcase
	endfunction

	// ==========================================================
	// cycle sequencer
	blams_pkg::blams_mstate_t st_q;
	blams_pkg::blams_kind_t kind_q;
	logic [1:0] byte_q;
	logic [7:0] left_q;
	logic [3:0] sel_q;
	logic [1:0] len_q;
	logic acked;
	assign acked = !dtack_s || !berr_s;
	// encoded lines for the incoming request and for the next block transfer
	logic [3:0] enc_req;
	logic [3:0] enc_nxt;
	assign enc_req = enc(req_kind, req_addr[1:0], req_len);
	assign enc_nxt = enc(kind_q, byte_q, len_q);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= blams_pkg::BLAMS_M_IDLE;
			kind_q <= blams_pkg::BLAMS_K_ADDR;
			byte_q <= blams_pkg::BYTE_0;
			left_q <= 8'h00;
			sel_q <= 4'hF;
			len_q <= 2'h0;
		end else begin
			case (st_q)
				blams_pkg::BLAMS_M_IDLE: begin
					if (req_valid) begin
						kind_q <= req_kind;
						byte_q <= req_addr[1:0]; // [RULE_01]
						len_q <= req_len;
						left_q <= req_beats;
						sel_q <= enc(req_kind, req_addr[1:0], req_len);
						st_q <= blams_pkg::BLAMS_M_ADDR;
					end
				end
				blams_pkg::BLAMS_M_ADDR: begin
					st_q <= (kind_q == blams_pkg::BLAMS_K_ADDR) ? blams_pkg::BLAMS_M_GAP
						: blams_pkg::BLAMS_M_DATA; // [RULE_09]
				end
				blams_pkg::BLAMS_M_DATA: begin
					if (acked) begin
						// next block transfer alternates strobes or pairs
						if (kind_q == blams_pkg::BLAMS_K_BLK1) begin
							byte_q <= byte_q + 2'h1; // [RULE_15]
						end else if (kind_q == blams_pkg::BLAMS_K_BLK2) begin
							byte_q <= byte_q + 2'h2; // [RULE_17]
						end
						st_q <= blams_pkg::BLAMS_M_GAP;
					end
				end
				blams_pkg::BLAMS_M_GAP: begin
					if (dtack_s && berr_s) begin
						if (left_q != 8'h00 && (kind_q == blams_pkg::BLAMS_K_BLK1 ||
								kind_q == blams_pkg::BLAMS_K_BLK2 || kind_q == blams_pkg::BLAMS_K_BLK4)) begin
							left_q <= left_q - 8'h01;
							// later transfers keep A01/LWORD from the first one
							sel_q <= {enc_nxt[3:2], sel_q[1:0]}; // [RULE_16]
							st_q <= blams_pkg::BLAMS_M_DATA;
						end else begin
							st_q <= blams_pkg::BLAMS_M_IDLE;
						end
					end
				end
				default: st_q <= blams_pkg::BLAMS_M_IDLE;
			endcase
		end
	end

	// bus line drivers
	logic [31:1] addr_q;
	logic [5:0] am_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addr_q <= '0;
			am_q <= '0;
		end else if (st_q == blams_pkg::BLAMS_M_IDLE && req_valid) begin
			addr_q <= {req_addr[31:2], enc_req[1]}; // [RULE_02]
			am_q <= req_am; // [RULE_19] [RULE_21]
		end
	end
	assign bus.addr = addr_q;
	assign bus.am = am_q;
	assign bus.as_n = (st_q == blams_pkg::BLAMS_M_IDLE);
	assign bus.lword_n = sel_q[0];
	// both strobes switch together from one register, so no transient pattern [RULE_05] [RULE_06]
	assign bus.ds1_n = (st_q == blams_pkg::BLAMS_M_DATA) ? sel_q[3] : 1'b1;
	assign bus.ds0_n = (st_q == blams_pkg::BLAMS_M_DATA) ? sel_q[2] : 1'b1;
	assign req_ready = (st_q == blams_pkg::BLAMS_M_IDLE);
	assign beat_done = (st_q == blams_pkg::BLAMS_M_DATA) && !dtack_s;
	assign beat_err = (st_q == blams_pkg::BLAMS_M_DATA) && !berr_s && dtack_s;
	assign busy = !req_ready;
endmodule
`default_nettype wire

//--- blams_assertions.sv
// checker: wire-level assertions on the backplane selection lines
`default_nettype none
module blams_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus lines
	input wire logic [31:1] addr,
	input wire logic [5:0] am,
	input wire logic as_n,
	input wire logic ds1_n,
	input wire logic ds0_n,
	input wire logic lword_n,
	input wire logic dtack_n,
	input wire logic berr_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic strb;
	logic rsv;
	// any strobe low; modifier neither defined nor user class
	assign strb = !ds1_n || !ds0_n;
	assign rsv = (am[5:4] != 2'h1) && !(am inside {6'h09, 6'h0A, 6'h0B, 6'h0D, 6'h0E,
		6'h0F, 6'h29, 6'h2D, 6'h39, 6'h3A, 6'h3B, 6'h3D, 6'h3E, 6'h3F});
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// properties
	property p_no_illegal;
		!as_n |-> !(!lword_n && addr[1] && (ds1_n != ds0_n));
	endproperty
	property p_both_strobes;
		!as_n && !lword_n && addr[1] && strb |-> !ds1_n && !ds0_n;
	endproperty
	property p_reserved;
		$fell(dtack_n) || $fell(berr_n) |-> !rsv;
	endproperty
	property p_addr_only;
		$fell(dtack_n) |-> strb && !as_n;
	endproperty
	property p_am_stable;
		!as_n && !$past(as_n) |-> $stable(am);
	endproperty
	property p_addr_stable;
		!as_n && !$past(as_n) |-> $stable(addr[31:2]);
	endproperty
	property p_strobe_hold;
		strb && dtack_n && berr_n |=> $stable({ds1_n, ds0_n});
	endproperty
	property p_release;
		$fell(dtack_n) |-> ##[1:4] !strb;
	endproperty
	property p_ack_hold;
		!dtack_n && strb |=> !dtack_n;
	endproperty
	a_no_illegal: assert property (p_no_illegal) else $error("illegal select");
	a_both_strobes: assert property (p_both_strobes) else $error("one strobe");
	a_reserved: assert property (p_reserved) else $error("reserved acked");
	a_addr_only: assert property (p_addr_only) else $error("ack no strobe");
	a_am_stable: assert property (p_am_stable) else $error("modifier moved");
	a_addr_stable: assert property (p_addr_stable) else $error("group moved");
	a_strobe_hold: assert property (p_strobe_hold) else $error("strobe moved");
	a_release: assert property (p_release) else $error("strobes kept");
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
	// main scenarios seen
	c_odd: cover property ($fell(dtack_n) && ds1_n && !ds0_n);
	c_quad: cover property ($fell(dtack_n) && !lword_n && !addr[1] && !ds1_n && !ds0_n);
	c_mid: cover property ($fell(dtack_n) && !lword_n && addr[1]);
	c_err: cover property ($fell(berr_n) && strb);
endmodule
`default_nettype wire

//--- test_byte_lane_am_select.sv
// testbench: master and slave ends joined across the selection lines
`default_nettype none
module test_byte_lane_am_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	blams_pkg::blams_kind_t req_kind = blams_pkg::BLAMS_K_SINGLE;
	logic [31:0] req_addr = 32'h0;
	logic [1:0] req_len = 2'h0;
	logic [5:0] req_am = 6'h39;
	logic [7:0] req_beats = 8'h0;
	logic user_am_en = 1'b0;
	logic local_done = 1'b0;
	logic local_err = 1'b0;
	logic [31:2] base_addr = 30'h0;
	int n_beat = 0;
	int n_berr = 0;
	logic req_ready;
	logic beat_done;
	logic beat_err;
	logic busy;
	logic sel_valid;
	logic [3:0] lane_en;
	logic [31:2] group_addr;
	blams_pkg::blams_width_t addr_width;
	logic [5:0] am_code;
	logic block_xfer;
	logic addr_only;
	int error_cnt = 0;
	int n_compared = 0;
	blams_if bus ();
	// either acknowledge line low
	logic ack_n;
	assign ack_n = bus.dtack_n && bus.berr_n;
	// the two ends and the checker on the lines between them
	blams_master blams_master_inst (.clk_sys, .rst, .bus(bus), .req_valid, .req_ready,
		.req_kind, .req_addr, .req_len, .req_am, .req_beats, .beat_done, .beat_err, .busy);
	blams_slave blams_slave_inst (.clk_sys, .rst, .bus(bus), .base_addr, .user_am_en,
		.sel_valid, .lane_en, .group_addr, .addr_width, .am_code, .block_xfer, .addr_only,
		.local_done, .local_err);
	blams_assertions blams_assertions_inst (.clk_sys, .rst, .addr(bus.addr), .am(bus.am),
		.as_n(bus.as_n), .ds1_n(bus.ds1_n), .ds0_n(bus.ds0_n), .lword_n(bus.lword_n),
		.dtack_n(bus.dtack_n), .berr_n(bus.berr_n));
	// 40 MHz clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// beats the master reports as done or failed
	always @(posedge clk_sys) begin
		if (beat_done === 1'b1) n_beat++;
		if (beat_err === 1'b1) n_berr++;
	end
	// ==========================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wait_lvl(ref logic s, input logic v);
		for (int i = 0; i < 200 && s !== v; i++) @(negedge clk_sys);
		if (s !== v) begin
			error_cnt++;
			$display("Error at %0t: wait ran out", $time);
			results();
		end
	endtask
	task automatic do_reset();
		rst = 1'b1;
		req_valid = 1'b0;
		local_done = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
	endtask
	// one request, then each beat answered by the local side; lanes per beat in nibbles
	task automatic xfer(input blams_pkg::blams_kind_t k, input logic [31:0] a,
		input logic [1:0] len, input logic [5:0] am, input logic [7:0] beats,
		input logic [15:0] lanes, input blams_pkg::blams_width_t w);
		int n0;
		int e0;
		n0 = n_beat;
		e0 = n_berr;
		wait_lvl(req_ready, 1'b1);
		req_kind = k;
		req_addr = a;
		req_len = len;
		req_am = am;
		req_beats = beats;
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		for (int b = 0; b <= beats; b++) begin
			wait_lvl(sel_valid, 1'b1);
			check(lane_en, lanes[4*b +: 4]);
			check(addr_only, 1'b0);
			if (b == 0) begin
				check(addr_width, w);
				check(group_addr, a[31:2]);
				check(am_code, am);
				check(block_xfer, am inside {6'h3F, 6'h3B, 6'h0F, 6'h0B});
				check(busy, 1'b1);
			end
			local_done = 1'b1;
			wait_lvl(ack_n, 1'b0);
			check(bus.dtack_n, local_err);
			local_done = 1'b0;
			wait_lvl(ack_n, 1'b1);
		end
		check(n_beat - n0, local_err ? 0 : beats + 1);
		check(n_berr - e0, local_err ? beats + 1 : 0);
	endtask
	// a cycle the slave must not take, even with the local side ready; reset frees the master
	task automatic refuse(input logic [31:0] a, input logic [5:0] am);
		wait_lvl(req_ready, 1'b1);
		req_kind = blams_pkg::BLAMS_K_SINGLE;
		req_addr = a;
		req_am = am;
		req_beats = 8'h0;
		req_valid = 1'b1;
		local_done = 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_sys);
			req_valid = 1'b0;
			check(sel_valid, 1'b0);
		end
		check(bus.dtack_n, 1'b1);
		do_reset();
	endtask
	// ==========================================================
	// main sequence
	initial begin
		logic [5:0] dat_am [10];
		logic [5:0] rsv_am [5];
		blams_pkg::blams_width_t w;
		dat_am = '{6'h3E, 6'h3D, 6'h3A, 6'h39, 6'h2D, 6'h29, 6'h0E, 6'h0D, 6'h0A, 6'h09};
		rsv_am = '{6'h3C, 6'h38, 6'h2A, 6'h08, 6'h00};
		do_reset();
		for (int i = 0; i < 4; i++) begin
			xfer(blams_pkg::BLAMS_K_SINGLE, i, 2'h0, 6'h39, 8'h0, 16'h1 << i, blams_pkg::BLAMS_W_STD);
		end
		xfer(blams_pkg::BLAMS_K_DOUBLE, 32'h0, 2'h0, 6'h39, 8'h0, 16'h3, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_DOUBLE, 32'h2, 2'h0, 6'h39, 8'h0, 16'hC, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_QUAD, 32'h0, 2'h0, 6'h3D, 8'h0, 16'hF, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_UNALIGN, 32'h0, 2'h0, 6'h39, 8'h0, 16'h7, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_UNALIGN, 32'h1, 2'h0, 6'h39, 8'h0, 16'hE, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_UNALIGN, 32'h1, 2'h1, 6'h39, 8'h0, 16'h6, blams_pkg::BLAMS_W_STD);
		// a failed beat answers with bus error instead of acknowledge
		local_err = 1'b1;
		xfer(blams_pkg::BLAMS_K_SINGLE, 32'h1, 2'h0, 6'h39, 8'h0, 16'h2, blams_pkg::BLAMS_W_STD);
		local_err = 1'b0;
		// address-only cycle: slave takes the address, moves no data
		wait_lvl(req_ready, 1'b1);
		req_kind = blams_pkg::BLAMS_K_ADDR;
		req_addr = 32'h2;
		req_am = 6'h39;
		req_beats = 8'h0;
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		wait_lvl(addr_only, 1'b1);
		check(addr_only, 1'b1);
		check(sel_valid, 1'b0);
		check(bus.dtack_n, 1'b1);
		xfer(blams_pkg::BLAMS_K_BLK1, 32'h2, 2'h0, 6'h3F, 8'h3, 16'h2184, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_BLK1, 32'h1, 2'h0, 6'h3B, 8'h1, 16'h0042, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_BLK2, 32'h2, 2'h0, 6'h0F, 8'h2, 16'h0C3C, blams_pkg::BLAMS_W_EXT);
		xfer(blams_pkg::BLAMS_K_BLK4, 32'h0, 2'h0, 6'h0B, 8'h1, 16'h00FF, blams_pkg::BLAMS_W_EXT);
		// each data and program modifier gives its width
		for (int i = 0; i < 10; i++) begin
			w = (dat_am[i][5:4] == 2'h3) ? blams_pkg::BLAMS_W_STD :
				(dat_am[i][5:4] == 2'h2) ? blams_pkg::BLAMS_W_SHORT : blams_pkg::BLAMS_W_EXT;
			xfer(blams_pkg::BLAMS_K_SINGLE, 32'h3, 2'h0, dat_am[i], 8'h0, 16'h8, w);
		end
		// upper address bits outside the class are not compared
		xfer(blams_pkg::BLAMS_K_SINGLE, 32'hAB000000, 2'h0, 6'h39, 8'h0, 16'h1, blams_pkg::BLAMS_W_STD);
		xfer(blams_pkg::BLAMS_K_SINGLE, 32'h00AB0000, 2'h0, 6'h29, 8'h0, 16'h1, blams_pkg::BLAMS_W_SHORT);
		refuse(32'hAB000000, 6'h09);
		// user codes only when enabled
		user_am_en = 1'b1;
		xfer(blams_pkg::BLAMS_K_SINGLE, 32'h0, 2'h0, 6'h10, 8'h0, 16'h1, blams_pkg::BLAMS_W_EXT);
		user_am_en = 1'b0;
		refuse(32'h0, 6'h10);
		for (int i = 0; i < 5; i++) refuse(32'h0, rsv_am[i]);
		// a window away from zero: same group hits, next group misses
		base_addr = 30'h1234;
		xfer(blams_pkg::BLAMS_K_SINGLE, 32'h48D0, 2'h0, 6'h29, 8'h0, 16'h1, blams_pkg::BLAMS_W_SHORT);
		refuse(32'h48D4, 6'h29);
		base_addr = 30'h0;
		xfer(blams_pkg::BLAMS_K_QUAD, 32'h0, 2'h0, 6'h0D, 8'h0, 16'hF, blams_pkg::BLAMS_W_EXT);
		results();
	end
endmodule
`default_nettype wire
